//--- bench/pin_verify_change_disable_tb.sv
module pin_verify_change_disable_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pvd_pkg::*;

    localparam logic [63:0] PA = 64'h1122334455667788;
    localparam logic [63:0] PB = 64'h8877665544332211;
    localparam logic [63:0] PW = 64'hdeadbeef00000000;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic perso = 1'b0;
    logic [63:0] perso_pin = '0;
    pvd_cmd_s cmd_bus;
    pvd_rsp_s rsp;
    logic [7:0] acc_ref = 8'h00;
    logic acc_multi = 1'b0;
    logic acc_ok;
    logic reval;
    int fail_count = 0;
    int n_compared = 0;

    pvd_pin_ctrl uut (.CLK_I(clk), .RST_I(rst), .PERSO_I(perso), .PERSO_PIN_I(perso_pin), .CMD_I(cmd_bus),
        .RSP_O(rsp), .ACC_REF_I(acc_ref), .ACC_MULTI_I(acc_multi), .ACC_OK_O(acc_ok), .SE_REVAL_O(reval));

    pvd_term_model term (.CLK_I(clk), .RSP_I(rsp), .CMD_O(cmd_bus));

    initial forever #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cmd(input pvd_op_e op, input logic [7:0] p1, input logic [7:0] p2, input logic [4:0] lc,
        input logic [63:0] pin, input logic [63:0] pin_new, input logic [15:0] exp);
        logic got;
        logic [15:0] sw;
        term.send(op, p1, p2, lc, pin, pin_new, got, sw);
        check({15'h0, got}, 16'h0001);
        check(sw, exp);
    endtask : cmd

    task automatic vfy(input logic [7:0] p2, input logic [63:0] pin, input logic [15:0] exp);
        cmd(OP_VERIFY, 8'h00, p2, LEN_PIN, pin, 64'h0, exp);
    endtask : vfy

    task automatic tries(input logic [7:0] p2, input logic [15:0] exp);
        cmd(OP_VERIFY, 8'h00, p2, LEN_NONE, 64'h0, 64'h0, exp);
    endtask : tries

    task automatic dis(input logic [7:0] p1, input logic [7:0] p2, input logic [63:0] pin,
        input logic [15:0] exp, input logic exp_reval);
        cmd(OP_DISABLE, p1, p2, LEN_PIN, pin, 64'h0, exp);
        check({15'h0, reval}, {15'h0, exp_reval});
    endtask : dis

    task automatic acc(input logic [7:0] ref_no, input logic multi, input logic exp);
        @(negedge clk);
        acc_ref = ref_no;
        acc_multi = multi;
        @(posedge clk);
        @(negedge clk);
        check({15'h0, acc_ok}, {15'h0, exp});
    endtask : acc

    task automatic session_reset;
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
    endtask : session_reset

    ////////////////////////////////////////////////////////////////
    initial
    begin
        #400000;
        fail_count++;
        wrap_up();
    end

    initial
    begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        perso = 1'b1;
        perso_pin = PA;
        @(negedge clk);
        perso = 1'b0;

        tries(8'h01, 16'h63c3);
        acc(8'h01, 1'b0, 1'b0);
        vfy(8'h01, PA, SW_OK);
        acc(8'h01, 1'b0, 1'b1);
        $display("test verify done");

        vfy(8'h02, PW, 16'h63c2);
        vfy(8'h02, PW, 16'h63c1);
        vfy(8'h02, PW, 16'h63c0);
        vfy(8'h02, PA, SW_BLOCKED);
        tries(8'h02, 16'h63c0);
        acc(8'h02, 1'b0, 1'b0);
        cmd(OP_CHANGE, 8'h00, 8'h02, LEN_CHG, PA, PB, SW_BLOCKED);
        dis(8'h00, 8'h02, PA, SW_BLOCKED, 1'b0);
        $display("test blocking done");

        vfy(8'h03, PW, 16'h63c2);
        session_reset();
        acc(8'h01, 1'b0, 1'b0);
        vfy(8'h03, PW, 16'h63c1);
        vfy(8'h03, PA, SW_OK);
        tries(8'h03, 16'h63c3);
        $display("test persistence done");

        cmd(OP_CHANGE, 8'h00, 8'h01, LEN_CHG, PW, PB, 16'h63c2);
        vfy(8'h01, PA, SW_OK);
        cmd(OP_CHANGE, 8'h00, 8'h01, LEN_CHG, PA, PB, SW_OK);
        vfy(8'h01, PA, 16'h63c2);
        vfy(8'h01, PB, SW_OK);
        tries(8'h01, 16'h63c3);
        $display("test change done");

        vfy(8'h00, PA, SW_BAD_P1P2);
        vfy(8'h41, PA, SW_BAD_P1P2);
        vfy(8'h05, PA, SW_NO_REF);
        cmd(OP_CHANGE, 8'h00, 8'h01, LEN_PIN, PB, PA, SW_BAD_LEN);
        cmd(OP_CHANGE, 8'h01, 8'h01, LEN_CHG, PB, PA, SW_BAD_P1P2);
        dis(8'h01, 8'h83, PA, SW_BAD_P1P2, 1'b0);
        dis(8'h85, 8'h83, PA, SW_NO_REF, 1'b0);
        dis(8'hc1, 8'h83, PA, SW_BAD_P1P2, 1'b0);
        $display("test coding done");

        vfy(8'h01, PW, 16'h63c2);
        dis(8'h81, 8'h81, PA, SW_OK, 1'b1);
        acc(8'h81, 1'b0, 1'b0);
        acc(8'h81, 1'b1, 1'b1);
        vfy(8'h01, PB, SW_OK);
        acc(8'h81, 1'b0, 1'b1);
        acc(8'h05, 1'b1, 1'b0);
        cmd(OP_CHANGE, 8'h00, 8'h81, LEN_CHG, PA, PB, SW_DENIED);
        dis(8'h81, 8'h81, PA, SW_DENIED, 1'b0);
        vfy(8'h81, PA, SW_DENIED);
        tries(8'h81, 16'h63c3);
        $display("test replacement done");

        dis(8'h00, 8'h82, PW, 16'h63c2, 1'b0);
        acc(8'h82, 1'b0, 1'b0);
        dis(8'h00, 8'h83, PA, SW_OK, 1'b1);
        acc(8'h83, 1'b0, 1'b1);
        $display("test disable done");
        wrap_up();
    end
endmodule : pin_verify_change_disable_tb

//--- bench/pvd_term_model.sv
module pvd_term_model
    import pvd_pkg::*;
(
    input wire logic CLK_I,
    input wire pvd_pkg::pvd_rsp_s RSP_I,
    output pvd_pkg::pvd_cmd_s CMD_O
);
    timeunit 1ns;
    timeprecision 1ps;

    initial CMD_O = '0;

    // PIN, new PIN and P2 flip after each command, and valid drops, so stale data never looks like a live request
    task automatic send(input pvd_op_e op, input logic [7:0] p1, input logic [7:0] p2, input logic [4:0] lc,
        input logic [63:0] pin, input logic [63:0] pin_new, output logic got, output logic [15:0] sw);
        @(negedge CLK_I);
        CMD_O = '{1'b1, op, p1, p2, lc, pin, pin_new};
        @(posedge CLK_I);
        @(negedge CLK_I);
        got = RSP_I.valid;
        sw = RSP_I.sw;
        CMD_O.valid = 1'b0;
        CMD_O.pin = ~pin;
        CMD_O.pin_new = ~pin_new;
        CMD_O.p2 = ~p2;
    endtask : send
endmodule : pvd_term_model

//--- hw/pvd_pin_ctrl.sv
// Function
// RQ1: Verify compares only enabled, unblocked PINs
// RQ2: Verified status is shared by all channels
// RQ3: PIN-guarded access needs verification unless disabled
// RQ4: Correct verify reloads attempts to three
// RQ5: Wrong verify decrements attempts on any channel
// RQ6: First wrong presentation answers 63C2
// RQ7: Second consecutive wrong answers 63C1, persistently
// RQ8: Third wrong blocks PIN, answers 63C0
// RQ9: Verify on blocked PIN answers 6983
// RQ10: Blocked PIN never satisfies access until unblocked
// RQ11: Empty verify returns remaining attempts 63CX
// RQ12: Empty verify on blocked PIN gives 63C0
// RQ13: P2 selects class and reference 01..1F; the code accepts references 01..04 only
// RQ14: Change carries old and new PIN, 16 bytes
// RQ15: Change needs enabled PIN; success installs new
// RQ16: New PIN is used at once everywhere
// RQ17: Wrong old PIN decrements, keeps PIN, blocks
// RQ18: Disable refused when disabled or blocked
// RQ19: Correct disable reloads three, marks disabled
// RQ20: Wrong disable decrements, stays enabled, blocks
// RQ21: Disabled PIN frees files, replacement excepted
// RQ22: Disable P1 codes replacement global key
// RQ23: Replacement key gets qualifier 08, then required
// RQ24: Successful disable triggers environment re-validation
// RQ25: Attempts, blocked, enabled survive session reset
module pvd_pin_ctrl
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PERSO_I,
    input wire logic [63:0] PERSO_PIN_I,
    input wire pvd_pkg::pvd_cmd_s CMD_I,
    output pvd_pkg::pvd_rsp_s RSP_O,
    input wire logic [7:0] ACC_REF_I,
    input wire logic ACC_MULTI_I,
    output logic ACC_OK_O,
    output logic SE_REVAL_O
);
    import pvd_pkg::*;

    ////////////////////////////////////////////////////////////////
    // State
    pvd_state_s q;
    pvd_state_s next_q;

    ////////////////////////////////////////////////////////////////
    // Command decode
    logic [4:0] ref_no;
    logic p2_bad;
    logic ref_ok;
    pvd_idx_t idx;
    pvd_nv_s sl;
    logic p1_bad;
    logic rep_req;
    logic rep_ok;
    logic [1:0] rep_idx;
    logic len_bad;
    logic query;
    logic match;
    logic go;
    logic [1:0] dec_tries;

    assign ref_no = CMD_I.p2[4:0];
    // Class in b8, b7..b6 must be zero, reference never zero
    assign p2_bad = (CMD_I.p2[6:5] != 2'h0) || (ref_no == 5'h00); // RQ13
    assign ref_ok = ref_no <= REF_MAX; // RQ13
    assign idx = {CMD_I.p2[7], 2'(ref_no - 5'h01)}; // RQ13
    assign sl = q.nv[idx];

    assign rep_req = (CMD_I.op == OP_DISABLE) && CMD_I.p1[7]; // RQ22
    assign rep_idx = 2'(CMD_I.p1[4:0] - 5'h01);
    assign rep_ok = !rep_req || (CMD_I.p1[4:0] <= REF_MAX);

    always_comb
    begin
        if (rep_req)
        begin
            p1_bad = (CMD_I.p1[6:5] != 2'h0) || (CMD_I.p1[4:0] == 5'h00); // RQ22
        end
        else
        begin
            // Only 00 is legal; 01 is a reserved_value
            p1_bad = CMD_I.p1 != 8'h00; // RQ22
        end
    end

    always_comb
    begin
        case (CMD_I.op)
            OP_VERIFY:
            begin
                len_bad = (CMD_I.lc != LEN_NONE) && (CMD_I.lc != LEN_PIN);
            end
            OP_CHANGE:
            begin
                len_bad = CMD_I.lc != LEN_CHG; // RQ14
            end
            OP_DISABLE:
            begin
                len_bad = CMD_I.lc != LEN_PIN;
            end
            default:
            begin
                len_bad = 1'b1;
            end
        endcase
    end

    assign query = (CMD_I.op == OP_VERIFY) && (CMD_I.lc == LEN_NONE);
    assign match = CMD_I.pin == sl.pin;
    assign dec_tries = sl.tries - 2'h1;
    // A presentation that reaches the PIN itself
    assign go = CMD_I.valid && !p1_bad && !p2_bad && !len_bad && ref_ok && rep_ok && !query;

    ////////////////////////////////////////////////////////////////
    // Access check decode
    logic [4:0] a_ref;
    logic a_ok;
    pvd_idx_t a_idx;
    pvd_nv_s as_;
    pvd_idx_t r_idx;

    assign a_ref = ACC_REF_I[4:0];
    assign a_ok = (ACC_REF_I[6:5] == 2'h0) && (a_ref != 5'h00) && (a_ref <= REF_MAX);
    assign a_idx = {ACC_REF_I[7], 2'(a_ref - 5'h01)};
    assign as_ = q.nv[a_idx];
    assign r_idx = {1'b0, as_.repl_idx};

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        next_q = q;
        next_q.rsp.valid = 1'b0;
        next_q.reval = 1'b0;

        if (CMD_I.valid)
        begin
            next_q.rsp.valid = 1'b1;
            if (p1_bad || p2_bad)
            begin
                next_q.rsp.sw = SW_BAD_P1P2;
            end
            else if (len_bad)
            begin
                next_q.rsp.sw = SW_BAD_LEN;
            end
            else if (!ref_ok || !rep_ok)
            begin
                next_q.rsp.sw = SW_NO_REF;
            end
            else if (query)
            begin
                // Blocked means zero attempts left, so 63C0
                next_q.rsp.sw = SW_RETRY | {14'h0000, sl.tries}; // RQ11 RQ12
            end
            else if (sl.blocked)
            begin
                next_q.rsp.sw = SW_BLOCKED; // RQ9
            end
            else if (!sl.enabled)
            begin
                next_q.rsp.sw = SW_DENIED; // RQ1 RQ15 RQ18
            end
            else if (match)
            begin
                next_q.rsp.sw = SW_OK;
                next_q.nv[idx].tries = TRY_INIT; // RQ4 RQ15 RQ19
                next_q.verified[idx] = 1'b1; // RQ2
                if (CMD_I.op == OP_CHANGE)
                begin
                    next_q.nv[idx].pin = CMD_I.pin_new; // RQ15 RQ16
                end
                if (CMD_I.op == OP_DISABLE)
                begin
                    next_q.nv[idx].enabled = 1'b0; // RQ19
                    next_q.reval = 1'b1; // RQ24
                    next_q.nv[idx].repl = rep_req; // RQ21
                    next_q.nv[idx].repl_idx = rep_idx;
                    if (rep_req)
                    begin
                        next_q.nv[{1'b0, rep_idx}].uq = UQ_USE; // RQ23
                    end
                end
            end
            else
            begin
                // Stored PIN stays; the count goes down on any channel
                next_q.nv[idx].tries = dec_tries; // RQ5 RQ17 RQ20
                next_q.verified[idx] = 1'b0;
                next_q.rsp.sw = SW_RETRY | {14'h0000, dec_tries}; // RQ6 RQ7 RQ8
                if (dec_tries == 2'h0)
                begin
                    next_q.nv[idx].blocked = 1'b1; // RQ8 RQ17 RQ20
                end
            end
        end

        // Access decision, shared by every channel
        if (!a_ok)
        begin
            next_q.acc_ok = 1'b0;
        end
        else if (as_.blocked && as_.enabled)
        begin
            next_q.acc_ok = 1'b0; // RQ10
        end
        else if (as_.enabled)
        begin
            next_q.acc_ok = q.verified[a_idx]; // RQ3
        end
        else if (as_.repl && !ACC_MULTI_I && q.nv[r_idx].uq == UQ_USE)
        begin
            next_q.acc_ok = q.verified[r_idx]; // RQ21 RQ23
        end
        else
        begin
            next_q.acc_ok = 1'b1; // RQ3 RQ21
        end

        // Personalisation loads the persistent part
        if (PERSO_I)
        begin
            for (int i = 0; i < SLOT_N; i++)
            begin
                next_q.nv[i].pin = PERSO_PIN_I;
                next_q.nv[i].tries = TRY_INIT;
                next_q.nv[i].blocked = 1'b0;
                next_q.nv[i].enabled = 1'b1;
                next_q.nv[i].repl = 1'b0;
                next_q.nv[i].repl_idx = 2'h0;
                next_q.nv[i].uq = UQ_OFF;
            end
            next_q.verified = '0;
        end

        // Session reset leaves the persistent part alone
        if (RST_I)
        begin
            next_q.verified = '0; // RQ25
            next_q.rsp = '0;
            next_q.reval = 1'b0;
            next_q.acc_ok = 1'b0;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        q <= next_q;
    end

    assign RSP_O = q.rsp;
    assign ACC_OK_O = q.acc_ok;
    assign SE_REVAL_O = q.reval;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I || PERSO_I);

    logic live;
    assign live = go && sl.enabled && !sl.blocked;

    tries_reload_a: assert property (live && match |=> q.nv[$past(idx)].tries == TRY_INIT) // RQ4
        else $error("attempts not reloaded after correct PIN");

    wrong_dec_a: assert property (live && !match |=> q.nv[$past(idx)].tries == $past(dec_tries)) // RQ5
        else $error("attempts not decremented after wrong PIN");

    first_wrong_a: assert property (live && !match && sl.tries == 2'h3 |=> RSP_O.sw == 16'h63c2) // RQ6
        else $error("first wrong PIN not answered 63C2");

    second_wrong_a: assert property (live && !match && sl.tries == 2'h2 |=> RSP_O.sw == 16'h63c1) // RQ7
        else $error("second wrong PIN not answered 63C1");

    third_block_a: assert property (live && !match && sl.tries == 2'h1 // RQ8
        |=> RSP_O.sw == 16'h63c0 && q.nv[$past(idx)].blocked)
        else $error("third wrong PIN did not block");

    blocked_sw_a: assert property (go && sl.blocked |=> RSP_O.valid && RSP_O.sw == SW_BLOCKED) // RQ9
        else $error("blocked PIN not answered 6983");

    retry_query_a: assert property (CMD_I.valid && query && !p1_bad && !p2_bad && ref_ok // RQ11 RQ12
        |=> RSP_O.sw == (SW_RETRY | {14'h0000, $past(sl.tries)}))
        else $error("empty verify did not report attempts");

    disabled_deny_a: assert property (go && !sl.blocked && !sl.enabled // RQ1 RQ18
        |=> RSP_O.sw == SW_DENIED && q.nv[$past(idx)].tries == $past(sl.tries))
        else $error("command on disabled PIN not refused");

    change_pin_a: assert property (live && match && CMD_I.op == OP_CHANGE // RQ15 RQ16
        |=> q.nv[$past(idx)].pin == $past(CMD_I.pin_new))
        else $error("new PIN not installed");

    wrong_keep_a: assert property (live && !match |=> q.nv[$past(idx)].pin == $past(sl.pin)) // RQ17
        else $error("wrong old PIN changed the stored PIN");

    // A second successful disable may follow back to back and pulse again
    disable_ok_a: assert property (live && match && CMD_I.op == OP_DISABLE // RQ19 RQ24
        |=> SE_REVAL_O && !q.nv[$past(idx)].enabled
        ##1 (SE_REVAL_O == $past(live && match && CMD_I.op == OP_DISABLE)))
        else $error("disable did not clear enable or pulse re-validation");

    disable_repl_a: assert property (live && match && rep_req // RQ23
        |=> q.nv[{1'b0, $past(rep_idx)}].uq == UQ_USE)
        else $error("replacement key qualifier not set");

    blocked_acc_a: assert property (a_ok && as_.blocked && as_.enabled |=> !ACC_OK_O) // RQ10
        else $error("blocked PIN satisfied access");

    unverified_acc_a: assert property (a_ok && as_.enabled && !q.verified[a_idx] |=> !ACC_OK_O) // RQ3
        else $error("access granted without verification");

    ////////////////////////////////////////////////////////////////
    // Answer coding, state keeping and access decision checks
    rsp_every_a: assert property (CMD_I.valid |=> RSP_O.valid) // RQ13
        else $error("command not answered");

    rsp_quiet_a: assert property (!CMD_I.valid |=> !RSP_O.valid) // RQ13
        else $error("answer without command");

    bad_p2_a: assert property (CMD_I.valid && (CMD_I.p2[6:5] != 2'h0 || CMD_I.p2[4:0] == 5'h00) // RQ13
        |=> RSP_O.sw == SW_BAD_P1P2)
        else $error("bad P2 not refused");

    no_ref_a: assert property (CMD_I.valid && !p1_bad && !p2_bad && !len_bad && ref_no > REF_MAX // RQ13
        |=> RSP_O.sw == SW_NO_REF)
        else $error("unknown reference not refused");

    change_len_a: assert property (CMD_I.valid && CMD_I.op == OP_CHANGE && CMD_I.p1 == 8'h00 && !p2_bad // RQ14
        && CMD_I.lc != LEN_CHG |=> RSP_O.sw == SW_BAD_LEN)
        else $error("change with wrong length not refused");

    p1_reserved_a: assert property (CMD_I.valid && CMD_I.op == OP_DISABLE && CMD_I.p1 == 8'h01 // RQ22
        |=> RSP_O.sw == SW_BAD_P1P2)
        else $error("reserved disable P1 not refused");

    refused_keep_a: assert property (CMD_I.valid && !go // RQ11
        |=> q.nv == $past(q.nv) && q.verified == $past(q.verified))
        else $error("refused or query command changed state");

    idle_keep_a: assert property (!CMD_I.valid |=> q.nv == $past(q.nv)) // RQ25
        else $error("persistent state changed without command");

    blocked_keep_a: assert property (go && sl.blocked |=> q.nv[$past(idx)] == $past(sl)) // RQ10
        else $error("blocked PIN state changed");

    verified_set_a: assert property (live && match |=> q.verified[$past(idx)]) // RQ2
        else $error("correct PIN did not set security status");

    verified_clr_a: assert property (live && !match |=> !q.verified[$past(idx)]) // RQ3
        else $error("wrong PIN kept security status");

    bad_ref_acc_a: assert property (ACC_REF_I[6:5] != 2'h0 || a_ref == 5'h00 || a_ref > REF_MAX // RQ13
        |=> !ACC_OK_O)
        else $error("access granted for unknown reference");

    verified_acc_a: assert property (a_ok && as_.enabled && !as_.blocked && q.verified[a_idx] // RQ3
        |=> ACC_OK_O)
        else $error("verified PIN did not grant access");

    free_acc_a: assert property (a_ok && !as_.enabled && (ACC_MULTI_I || !as_.repl) |=> ACC_OK_O) // RQ21
        else $error("disabled PIN did not free access");

    repl_acc_a: assert property (a_ok && !as_.enabled && as_.repl && !ACC_MULTI_I // RQ23
        && q.nv[r_idx].uq == UQ_USE |=> ACC_OK_O == $past(q.verified[r_idx]))
        else $error("replacement key not required");

    reval_only_a: assert property (!(live && match && CMD_I.op == OP_DISABLE) |=> !SE_REVAL_O) // RQ24
        else $error("re-validation without successful disable");

    verify_pass_c: cover property (live && match && CMD_I.op == OP_VERIFY ##1 ACC_OK_O);
    block_c: cover property (live && !match && sl.tries == 2'h1);
    disable_repl_c: cover property (live && match && rep_req);
    query_c: cover property (CMD_I.valid && query);
    repl_acc_c: cover property (a_ok && as_.repl && !as_.enabled && !ACC_MULTI_I ##1 ACC_OK_O);
endmodule : pvd_pin_ctrl

//--- hw/pvd_pkg.sv
package pvd_pkg;
    localparam int SLOT_N = 8;
    localparam logic [4:0] REF_MAX = 5'h04;
    localparam logic [1:0] TRY_INIT = 2'h3;
    localparam logic [7:0] UQ_USE = 8'h08;
    localparam logic [7:0] UQ_OFF = 8'h00;
    localparam logic [4:0] LEN_NONE = 5'h00;
    localparam logic [4:0] LEN_PIN = 5'h08;
    localparam logic [4:0] LEN_CHG = 5'h10;
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_RETRY = 16'h63c0;
    localparam logic [15:0] SW_BLOCKED = 16'h6983;
    localparam logic [15:0] SW_DENIED = 16'h6985;
    localparam logic [15:0] SW_BAD_LEN = 16'h6700;
    localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
    localparam logic [15:0] SW_NO_REF = 16'h6a88;

    typedef enum logic [1:0] {OP_VERIFY, OP_CHANGE, OP_DISABLE} pvd_op_e;
    typedef logic [2:0] pvd_idx_t;

    typedef struct packed {
        logic valid;
        pvd_op_e op;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [4:0] lc;
        logic [63:0] pin;
        logic [63:0] pin_new;
    } pvd_cmd_s;

    typedef struct packed {
        logic valid;
        logic [15:0] sw;
    } pvd_rsp_s;

    typedef struct packed {
        logic [63:0] pin;
        logic [1:0] tries;
        logic blocked;
        logic enabled;
        logic repl;
        logic [1:0] repl_idx;
        logic [7:0] uq;
    } pvd_nv_s;

    typedef struct packed {
        pvd_nv_s [SLOT_N-1:0] nv;
        logic [SLOT_N-1:0] verified;
        pvd_rsp_s rsp;
        logic reval;
        logic acc_ok;
    } pvd_state_s;
endpackage : pvd_pkg
